// ==== inc/apl_if.sv ====
/*
 * Processor port between host software sequencer and the register bank.
 * Assumes both ends run on the same clock; read data lags rd_stb by one.
 */
`timescale 1ns/10ps
interface apl_if;
   logic cmd_stb;
   logic rd_stb;
   logic wr_stb;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport host (output cmd_stb, output rd_stb, output wr_stb,
                 output wdata, input rdata);
   modport dev (input cmd_stb, input rd_stb, input wr_stb,
                input wdata, output rdata);
endinterface

// ==== inc/apl_pkg.sv ====
/*
 * Shared constants and types for the aperiodic transfer list register bank:
 * command codes, reset values, field widths, event bits, host register map.
 * Assumes one 100 MHz clock shared by both ends of the processor port.
 */
package apl_pkg;
   // ----------------------------------------------------------------
   // Command codes (read codes, write codes have bit 7 set)
   // ----------------------------------------------------------------
   localparam logic [7:0] APL_BUFSZ_RD = 8'h34;
   localparam logic [7:0] APL_BUFSZ_WR = 8'hB4;
   localparam logic [7:0] APL_PORT_RD = 8'h44;
   localparam logic [7:0] APL_PORT_WR = 8'hC4;
   localparam logic [7:0] APL_BLK_RD = 8'h54;
   localparam logic [7:0] APL_BLK_WR = 8'hD4;
   localparam logic [7:0] APL_DONE_RD = 8'h1B;
   localparam logic [7:0] APL_SKIP_RD = 8'h1C;
   localparam logic [7:0] APL_SKIP_WR = 8'h9C;
   localparam logic [7:0] APL_LAST_RD = 8'h1D;
   localparam logic [7:0] APL_LAST_WR = 8'h9D;
   localparam logic [7:0] APL_ACT_RD = 8'h1E;
   localparam logic [7:0] APL_EVST_RD = 8'h24;
   localparam logic [7:0] APL_EVST_WR = 8'hA4;
   localparam logic [7:0] APL_EVMSK_RD = 8'h25;
   localparam logic [7:0] APL_EVMSK_WR = 8'hA5;
   localparam int APL_WR_BIT = 7;
   // ----------------------------------------------------------------
   // Reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [15:0] APL_BUFSZ_RST = 16'h0200;
   localparam logic [15:0] APL_BUF_MAX = 16'h1000;
   localparam logic [15:0] APL_PORT_START = 16'h0000;
   localparam logic [15:0] APL_WORD_BYTES = 16'h0002;
   localparam logic [9:0] APL_BLK_RST = 10'h000;
   localparam logic [31:0] APL_MAP_RST = 32'h0000_0000;
   localparam logic [4:0] APL_ACT_RST = 5'h00;
   localparam int APL_BLK_W = 10;
   localparam int APL_IDX_W = 5;
   // ----------------------------------------------------------------
   // Event bits and host register offsets
   // ----------------------------------------------------------------
   localparam int APL_EV_EOT = 0;
   localparam int APL_EV_DONE = 1;
   localparam int APL_EV_W = 2;
   localparam logic [3:0] APL_HOFS_CTRL = 4'h0;
   localparam logic [3:0] APL_HOFS_WDATA = 4'h4;
   localparam logic [3:0] APL_HOFS_RDATA = 4'h8;
   localparam logic [3:0] APL_HOFS_STAT = 4'hC;
   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {HS_IDLE, HS_CMD, HS_DATA, HS_RWAIT} apl_hst_e;
   typedef struct packed {
      logic [7:0] cmd;
      logic hi;
      logic [15:0] bufsz;
      logic [9:0] blk;
      logic [31:0] done;
      logic [31:0] skip;
      logic [31:0] last;
      logic [4:0] act;
      logic [15:0] ptr;
      logic ended;
      logic [15:0] shadow;
      logic [15:0] rdata;
      logic [1:0] ev;
      logic [1:0] mask;
      logic eot;
   } apl_dev_s;
   typedef struct packed {
      apl_hst_e st;
      logic [7:0] code;
      logic [10:0] left;
      logic [15:0] wh;
      logic wv;
      logic [15:0] rh;
      logic rv;
      logic [31:0] rdo;
      logic cmd_s;
      logic rd_s;
      logic wr_s;
      logic [15:0] wd;
   } apl_host_s;
endpackage

// ==== rtl/apl_dev.sv ====
/*
 * Aperiodic transfer list register bank with sequential buffer port and
 * descriptor walker (active index, skip, last, done maps, events).
 * Assumes the processor port shares clk_i and the core supplies the
 * transfer byte count and descriptor completion strobes.
 */
`timescale 1ns/10ps
module apl_dev
   import apl_pkg::*;
#(
   parameter int BUF_BYTES = 4096
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   apl_if.dev bus,
   input wire logic [15:0] xfer_count_i,
   input wire logic ack_done_i,
   input wire logic advance_i,
   input wire logic [10:0] core_addr_i,
   output logic [15:0] core_rdata_o,
   output logic proc_valid_o,
   output logic [4:0] active_index_o,
   output logic [15:0] desc_addr_o,
   output logic [9:0] block_size_o,
   output logic [15:0] buffer_size_o,
   output logic eot_o,
   output logic irq_o
);
   localparam int WORDS = BUF_BYTES / 2;
   localparam int AW = $clog2(WORDS);

   apl_dev_s r_reg;
   apl_dev_s r_next;
   logic [15:0] mem [WORDS];
   logic [AW-1:0] waddr;
   logic port_rd;
   logic port_wr;
   logic in_range;

   // ----------------------------------------------------------------
   // Port access qualification
   // ----------------------------------------------------------------
   // Word address taken straight from the byte pointer, no host address
   assign waddr = r_reg.ptr[AW:1];
   // Accesses past the programmed buffer size are dropped
   assign in_range = r_reg.ptr < r_reg.bufsz;
   assign port_rd = bus.rd_stb && r_reg.cmd == APL_PORT_RD && in_range;
   assign port_wr = bus.wr_stb && r_reg.cmd == APL_PORT_WR && in_range;

   // ----------------------------------------------------------------
   // Buffer memory
   // ----------------------------------------------------------------
   // Port writes and registered core read
   always_ff @(posedge clk_i) begin
      if (port_wr) begin
         mem[waddr] <= bus.wdata;
      end
      core_rdata_o <= mem[core_addr_i[AW-1:0]];
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Register access, pointer, walker and events in one place
   always_comb begin
      logic [31:0] done_set;
      logic [1:0] ev_set;
      logic [1:0] ev_clr;
      logic step;
      logic [15:0] ptr_inc;
      done_set = '0;
      ev_set = '0;
      ev_clr = '0;
      step = 1'b0;
      ptr_inc = r_reg.ptr + APL_WORD_BYTES;
      r_next = r_reg;
      r_next.rdata = 16'h0000;
      r_next.eot = 1'b0;

      // Command phase selects the register and resets word order
      if (bus.cmd_stb) begin
         r_next.cmd = bus.wdata[7:0];
         r_next.hi = 1'b0;
         if (bus.wdata[7:0] == APL_PORT_RD ||
             bus.wdata[7:0] == APL_PORT_WR) begin
            r_next.ptr = APL_PORT_START;
            r_next.ended = 1'b0;
         end
      end

      // Reads; unused upper bits come back as zero
      if (bus.rd_stb) begin
         case (r_reg.cmd)
            APL_BUFSZ_RD: r_next.rdata = r_reg.bufsz;
            APL_BLK_RD: r_next.rdata = {6'h00, r_reg.blk};
            APL_ACT_RD: r_next.rdata = {11'h000, r_reg.act};
            APL_EVST_RD: r_next.rdata = {14'h0000, r_reg.ev};
            APL_EVMSK_RD: r_next.rdata = {14'h0000, r_reg.mask};
            APL_PORT_RD: begin
               if (in_range) begin
                  r_next.rdata = mem[waddr];
               end
            end
            APL_DONE_RD: begin
               // Low word first; whole map snapshotted and cleared then
               if (!r_reg.hi) begin
                  r_next.rdata = r_reg.done[15:0];
                  r_next.shadow = r_reg.done[31:16];
                  r_next.done = APL_MAP_RST;
               end else begin
                  r_next.rdata = r_reg.shadow;
               end
            end
            APL_SKIP_RD: begin
               r_next.rdata = r_reg.hi ? r_reg.skip[31:16] :
                              r_reg.skip[15:0];
            end
            APL_LAST_RD: begin
               r_next.rdata = r_reg.hi ? r_reg.last[31:16] :
                              r_reg.last[15:0];
            end
            default: r_next.rdata = 16'h0000;
         endcase
         r_next.hi = ~r_reg.hi;
      end

      // Writes; reserved bits are simply not stored
      if (bus.wr_stb) begin
         case (r_reg.cmd)
            APL_BUFSZ_WR: begin
               // Oversized requests clamp to the physical buffer
               r_next.bufsz = (bus.wdata > APL_BUF_MAX) ? APL_BUF_MAX :
                              bus.wdata;
            end
            APL_BLK_WR: r_next.blk = bus.wdata[9:0];
            APL_EVST_WR: ev_clr = bus.wdata[1:0];
            APL_EVMSK_WR: r_next.mask = bus.wdata[1:0];
            APL_SKIP_WR: begin
               if (r_reg.hi) begin
                  r_next.skip[31:16] = bus.wdata;
               end else begin
                  r_next.skip[15:0] = bus.wdata;
               end
            end
            APL_LAST_WR: begin
               if (r_reg.hi) begin
                  r_next.last[31:16] = bus.wdata;
               end else begin
                  r_next.last[15:0] = bus.wdata;
               end
            end
            default: r_next.hi = r_reg.hi;
         endcase
         r_next.hi = ~r_reg.hi;
      end

      // Burst pointer steps by one word per access
      if (port_rd || port_wr) begin
         r_next.ptr = ptr_inc;
         // End flagged once, when the loaded byte count is reached
         if (!r_reg.ended && ptr_inc >= xfer_count_i) begin
            r_next.ended = 1'b1;
            r_next.eot = 1'b1;
            ev_set[APL_EV_EOT] = 1'b1;
         end
      end

      // Descriptor walker: skipped entries are passed over each cycle
      if (r_reg.skip[r_reg.act]) begin
         step = 1'b1;
      end else if (ack_done_i) begin
         done_set[r_reg.act] = 1'b1;
         ev_set[APL_EV_DONE] = 1'b1;
         step = advance_i;
      end else begin
         step = advance_i;
      end
      if (step) begin
         r_next.act = r_reg.last[r_reg.act] ? APL_ACT_RST :
                      r_reg.act + 5'h01;
      end

      // Completion wins over a clear in the same cycle
      r_next.done = r_next.done | done_set;
      r_next.ev = (r_reg.ev & ~ev_clr) | ev_set;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg <= '{cmd: 8'h00, hi: 1'b0, bufsz: APL_BUFSZ_RST,
                    blk: APL_BLK_RST, done: APL_MAP_RST,
                    skip: APL_MAP_RST, last: APL_MAP_RST,
                    act: APL_ACT_RST, ptr: APL_PORT_START,
                    ended: 1'b0, shadow: 16'h0000, rdata: 16'h0000,
                    ev: 2'h0, mask: 2'h0, eot: 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Block base of the active descriptor for the core
   assign desc_addr_o = 16'(r_reg.act) * 16'(r_reg.blk);
   assign bus.rdata = r_reg.rdata;
   assign proc_valid_o = ~r_reg.skip[r_reg.act];
   assign active_index_o = r_reg.act;
   assign block_size_o = r_reg.blk;
   assign buffer_size_o = r_reg.bufsz;
   assign eot_o = r_reg.eot;
   assign irq_o = |(r_reg.ev & r_reg.mask);
endmodule

// ==== rtl/apl_host.sv ====
/*
 * Host-side sequencer: software posts a command code and word count, then
 * feeds or drains one word at a time through its own small register map.
 * Assumes the register bank sits on the same clock behind apl_if.
 */
`timescale 1ns/10ps
module apl_host
   import apl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   apl_if.host bus,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);
   apl_host_s r_reg;
   apl_host_s r_next;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Order matters: pop before capture, consume before refill
   always_comb begin
      r_next = r_reg;
      r_next.cmd_s = 1'b0;
      r_next.rd_s = 1'b0;
      r_next.wr_s = 1'b0;
      r_next.rdo = 32'h0000_0000;

      // Software reads; RDATA pops the holding word
      if (rd_i) begin
         case (addr_i)
            APL_HOFS_RDATA: begin
               r_next.rdo = {16'h0000, r_reg.rh};
               r_next.rv = 1'b0;
            end
            APL_HOFS_STAT: begin
               r_next.rdo = {29'h0, r_reg.rv, r_reg.wv,
                             r_reg.st != HS_IDLE};
            end
            default: r_next.rdo = 32'h0000_0000;
         endcase
      end

      // Sequencer; code bit 7 tells write from read
      case (r_reg.st)
         HS_CMD: begin
            r_next.cmd_s = 1'b1;
            r_next.wd = {8'h00, r_reg.code};
            r_next.st = (r_reg.left == 11'h000) ? HS_IDLE : HS_DATA;
         end
         HS_DATA: begin
            if (r_reg.code[APL_WR_BIT]) begin
               // Stall until software has supplied the next word
               if (r_reg.wv) begin
                  r_next.wr_s = 1'b1;
                  r_next.wd = r_reg.wh;
                  r_next.wv = 1'b0;
                  r_next.left = r_reg.left - 11'h001;
                  if (r_reg.left == 11'h001) begin
                     r_next.st = HS_IDLE;
                  end
               end
            end else if (!r_reg.rv) begin
               r_next.rd_s = 1'b1;
               r_next.st = HS_RWAIT;
            end
         end
         HS_RWAIT: begin
            // Bank registers its answer, so the word stands only once
            // the read strobe has left the bus; capturing earlier sees 0
            if (!r_reg.rd_s) begin
               r_next.rh = bus.rdata;
               r_next.rv = 1'b1;
               r_next.left = r_reg.left - 11'h001;
               r_next.st = (r_reg.left == 11'h001) ? HS_IDLE : HS_DATA;
            end
         end
         default: r_next.st = HS_IDLE;
      endcase

      // Software writes; a new order is only taken when idle
      if (wr_i) begin
         case (addr_i)
            APL_HOFS_CTRL: begin
               // Word count and status are the caller's job beforehand
               if (r_reg.st == HS_IDLE) begin
                  r_next.code = wdata_i[7:0];
                  r_next.left = wdata_i[18:8];
                  r_next.st = HS_CMD;
               end
            end
            APL_HOFS_WDATA: begin
               r_next.wh = wdata_i[15:0];
               r_next.wv = 1'b1;
            end
            default: r_next.wv = r_next.wv;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r_reg <= '{st: HS_IDLE, code: 8'h00, left: 11'h000,
                    wh: 16'h0000, wv: 1'b0, rh: 16'h0000, rv: 1'b0,
                    rdo: 32'h0000_0000, cmd_s: 1'b0, rd_s: 1'b0,
                    wr_s: 1'b0, wd: 16'h0000};
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus.cmd_stb = r_reg.cmd_s;
   assign bus.rd_stb = r_reg.rd_s;
   assign bus.wr_stb = r_reg.wr_s;
   assign bus.wdata = r_reg.wd;
   assign rdata_o = r_reg.rdo;
endmodule

// ==== tb/apl_chk_sva.sv ====
/*
 * Checker for the processor port and descriptor walker of the aperiodic
 * transfer list bank. Assumes one clock and an active-low async reset;
 * the bench instantiates it beside the interface joining both ends.
 */
`timescale 1ns/10ps
module apl_chk_sva
   import apl_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cmd_stb,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [15:0] rdata,
   input wire logic advance_i,
   input wire logic proc_valid_o,
   input wire logic [4:0] active_index_o,
   input wire logic [15:0] buffer_size_o,
   input wire logic eot_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   // Index moves one on, or wraps to the first descriptor
   sequence s_step;
      ##1 (active_index_o == $past(active_index_o) + 5'h01 ||
           active_index_o == 5'h00);
   endsequence

   // ----------------------------------------------------------------
   // Port phases
   // ----------------------------------------------------------------
   property p_rdata_idle;
      !$past(rd_stb) |-> rdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data seen without a read strobe");

   // One phase per cycle, never a command with a data phase
   property p_one_phase;
      $countones({cmd_stb, rd_stb, wr_stb}) <= 1;
   endproperty
   a_one_phase: assert property (p_one_phase)
      else $error("two port phases in one cycle");

   property p_bufsz_max;
      buffer_size_o <= APL_BUF_MAX;
   endproperty
   a_bufsz_max: assert property (p_bufsz_max)
      else $error("buffer size above its maximum");

   // ----------------------------------------------------------------
   // End of transfers
   // ----------------------------------------------------------------
   property p_eot_cause;
      eot_o |-> $past(rd_stb || wr_stb);
   endproperty
   a_eot_cause: assert property (p_eot_cause)
      else $error("end of transfers without a data access");

   property p_eot_pulse;
      eot_o |=> !eot_o;
   endproperty
   a_eot_pulse: assert property (p_eot_pulse)
      else $error("end of transfers longer than one cycle");

   // ----------------------------------------------------------------
   // Walker
   // ----------------------------------------------------------------
   property p_idx_adv;
      advance_i && proc_valid_o |-> s_step;
   endproperty
   a_idx_adv: assert property (p_idx_adv)
      else $error("index did not step or wrap on advance");

   // Skipped descriptors are passed over at once
   property p_idx_skip;
      !proc_valid_o |-> s_step;
   endproperty
   a_idx_skip: assert property (p_idx_skip)
      else $error("index stayed on a skipped descriptor");

   property p_idx_hold;
      proc_valid_o && !advance_i |=> $stable(active_index_o);
   endproperty
   a_idx_hold: assert property (p_idx_hold)
      else $error("index moved without an advance");
endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench: host sequencer and register bank joined by the
 * interface; software side driven through the host register port.
 * Assumes a 100 MHz clock and the package command codes.
 */
`timescale 1ns/10ps
module tb
   import apl_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [15:0] xfer_count_i = 16'h0;
   logic ack_done_i = 1'b0;
   logic advance_i = 1'b0;
   logic [10:0] core_addr_i = 11'h0;
   logic [15:0] core_rdata_o, desc_addr_o, buffer_size_o;
   logic [9:0] block_size_o;
   logic [4:0] active_index_o;
   logic proc_valid_o, eot_o, irq_o;
   logic [31:0] r;
   int err_count = 0;
   int comparisons = 0;
   int eot_seen = 0;
   int cycles = 0;
   logic [7:0] rc [7] = '{APL_BUFSZ_RD, APL_BLK_RD, APL_SKIP_RD,
      APL_LAST_RD, APL_DONE_RD, APL_ACT_RD, 8'h35};
   int rn [7] = '{1, 1, 2, 2, 2, 1, 1};
   logic [31:0] re [7] = '{32'h0200, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0};

   apl_if bus_if();
   apl_host apl_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o));
   apl_dev apl_dev_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
      .xfer_count_i(xfer_count_i), .ack_done_i(ack_done_i),
      .advance_i(advance_i), .core_addr_i(core_addr_i),
      .core_rdata_o(core_rdata_o), .proc_valid_o(proc_valid_o),
      .active_index_o(active_index_o), .desc_addr_o(desc_addr_o),
      .block_size_o(block_size_o), .buffer_size_o(buffer_size_o),
      .eot_o(eot_o), .irq_o(irq_o));
   apl_chk_sva apl_chk_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cmd_stb(bus_if.cmd_stb), .rd_stb(bus_if.rd_stb),
      .wr_stb(bus_if.wr_stb), .rdata(bus_if.rdata), .advance_i(advance_i),
      .proc_valid_o(proc_valid_o), .active_index_o(active_index_o),
      .buffer_size_o(buffer_size_o), .eot_o(eot_o));

   // ----------------------------------------------------------------
   // Clock, end-of-transfer counter and hang guard
   // ----------------------------------------------------------------
   always #5 clk_i = ~clk_i;

   // Whole run is a few hundred cycles; ceiling well clear of that
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (eot_o === 1'b1)
         eot_seen = eot_seen + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_count = err_count + 1;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Strobes rise one edge after the last fell, never in the same step
   task automatic hwr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic hrd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   // Bounded poll of one status bit
   task automatic wait_st(input int b, input logic v);
      logic [31:0] s;
      int k;
      k = 0;
      do begin
         hrd(APL_HOFS_STAT, s);
         k++;
      end while (s[b] !== v && k < 40);
      chk("status bit", {31'h0, v}, {31'h0, s[b]});
   endtask

   function automatic logic [15:0] pat(input int i);
      return 16'hC000 + i[15:0];
   endfunction

   // One command with n words; port words follow a fixed pattern
   task automatic xfer(input logic [7:0] c, input int n,
                       input logic [31:0] d, output logic [31:0] q);
      logic [31:0] w;
      q = 32'h0;
      if (c[APL_WR_BIT])
         hwr(APL_HOFS_WDATA, (c == APL_PORT_WR) ? pat(0) : d[15:0]);
      hwr(APL_HOFS_CTRL, {13'h0, n[10:0], c});
      for (int i = 0; i < n; i++) begin
         if (c[APL_WR_BIT] && i > 0) begin
            wait_st(1, 1'b0);
            hwr(APL_HOFS_WDATA, (c == APL_PORT_WR) ? pat(i) : d[31:16]);
         end else if (!c[APL_WR_BIT]) begin
            wait_st(2, 1'b1);
            hrd(APL_HOFS_RDATA, w);
            if (i < 2)
               q[i*16 +: 16] = w[15:0];
            if (c == APL_PORT_RD)
               chk("port word", {16'h0, pat(i)}, w);
         end
      end
      wait_st(0, 1'b0);
      // Busy drops as the last data phase goes out; let it land
      repeat (2) @(posedge clk_i);
   endtask

   task automatic pulse(input logic adv);
      @(posedge clk_i);
      advance_i <= adv;
      ack_done_i <= !adv;
      @(posedge clk_i);
      advance_i <= 1'b0;
      ack_done_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      // Reset values, unknown code reads zero
      for (int k = 0; k < 7; k++) begin
         xfer(rc[k], rn[k], 32'h0, r);
         chk("reset value", re[k], r);
      end
      xfer(APL_BUFSZ_WR, 1, 32'h0800, r);
      xfer(APL_BUFSZ_RD, 1, 32'h0, r);
      chk("buffer size", 32'h0800, r);
      xfer(APL_BUFSZ_WR, 1, 32'h2000, r);
      xfer(APL_BUFSZ_RD, 1, 32'h0, r);
      chk("buffer size", {16'h0, APL_BUF_MAX}, r);
      chk("size out", {16'h0, APL_BUF_MAX}, {16'h0, buffer_size_o});
      // Reserved block size bits dropped
      xfer(APL_BLK_WR, 1, 32'hFFF8, r);
      xfer(APL_BLK_RD, 1, 32'h0, r);
      chk("block size", 32'h03F8, r);
      chk("block out", 32'h03F8, {22'h0, block_size_o});
      xfer(APL_SKIP_WR, 2, 32'h8001_0000, r);
      xfer(APL_SKIP_RD, 2, 32'h0, r);
      chk("skip map", 32'h8001_0000, r);
      xfer(APL_LAST_WR, 2, 32'h5A00_0002, r);
      xfer(APL_LAST_RD, 2, 32'h0, r);
      chk("last map", 32'h5A00_0002, r);
      // Port bursts of four words against an eight-byte count
      @(posedge clk_i);
      xfer_count_i <= 16'h0008;
      xfer(APL_PORT_WR, 4, 32'h0, r);
      chk("eot count", 32'd1, eot_seen);
      xfer(APL_PORT_RD, 4, 32'h0, r);
      chk("eot count", 32'd2, eot_seen);
      @(posedge clk_i);
      core_addr_i <= 11'd2;
      repeat (2) @(posedge clk_i);
      chk("core word", {16'h0, pat(2)}, {16'h0, core_rdata_o});
      // Event raised, masked through to the interrupt, then cleared
      xfer(APL_EVST_RD, 1, 32'h0, r);
      chk("event status", 32'h1, r);
      chk("irq", 32'h0, {31'h0, irq_o});
      xfer(APL_EVMSK_WR, 1, 32'h1, r);
      chk("irq", 32'h1, {31'h0, irq_o});
      xfer(APL_EVST_WR, 1, 32'h1, r);
      chk("irq", 32'h0, {31'h0, irq_o});
      // Walker: done, step, wrap on last, skip
      pulse(1'b0);
      pulse(1'b1);
      chk("active index", 32'd1, {27'h0, active_index_o});
      chk("desc addr", 32'h03F8, {16'h0, desc_addr_o});
      pulse(1'b1);
      chk("active index", 32'd0, {27'h0, active_index_o});
      xfer(APL_SKIP_WR, 2, 32'h8001_0001, r);
      xfer(APL_ACT_RD, 1, 32'h0, r);
      chk("active index", 32'd1, r);
      pulse(1'b0);
      xfer(APL_DONE_RD, 2, 32'h0, r);
      chk("done map", 32'h3, r);
      xfer(APL_DONE_RD, 2, 32'h0, r);
      chk("done map", 32'h0, r);
      xfer(APL_EVST_RD, 1, 32'h0, r);
      chk("event status", 32'h2, r);
      // Descriptor 0 still holds data, so clearing its skip is safe
      xfer(APL_SKIP_WR, 2, 32'h0, r);
      pulse(1'b1);
      repeat (3) @(posedge clk_i);
      chk("active index", 32'd0, {27'h0, active_index_o});
      finish_test();
   end
endmodule
